// [rtl/tdc_measure_adjust.sv]
// Function
// (RQ1) Software waits for loop lock before delay work; measurement alone needs none.
// (RQ2) Samples per measurement are sixty-four times two to the averaging exponent.
// (RQ3) Manual bit must be set for a software-triggered measurement.
// (RQ4) Five-bit fields pick the source and target sync channels.
// (RQ5) Two bits pick falling instead of rising edge for source and target.
// (RQ6) Writing one then zero to the clear bit wipes measurement errors.
// (RQ7) Setting the arm bit starts a measurement with current settings.
// (RQ8) Software clears the arm bit after reading the result.
// (RQ9) Measurement busy holds for the whole sampling period, visible on debug pins.
// (RQ10) Two-bit error field reports errors seen during measurement.
// (RQ11) Postprocess busy rises after measurement ends, falls once results are out.
// (RQ12) 24-bit phase result readable over three bytes, high byte at top.
// (RQ13) Six-bit fine field sets the analog target delay.
// (RQ14) Sixteen-bit coarse delta is added to the existing coarse delay.
// (RQ15) Fine and coarse values reach the shift block through busy-clocked flops; the coarse field also reloads on each step.
// (RQ16) Single_cycle_apply applies all in one cycle, else small or big steps.
// (RQ17) Start bit begins adjustment; delay busy holds until done.
// (RQ18) Per-channel fine delay and low three coarse bits are readable.
// (RQ19) Each channel has a signed 16-bit desired offset.
// (RQ20) Signed 21-bit common offset adds to every channel.
// (RQ21) Result scaled by output divider and two to the ninth before offset.
// (RQ22) Closed loop repeats measurement and adjustment to remove residual error.
// (RQ23) Result registers hold the last completed value until the next one.
`timescale 1ns/10ps
`default_nettype none
module tdc_measure_adjust
import tdc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [TDC_NUM_CH-1:0] SYNC_CHANNEL_IN,
    input wire logic PLL_LOCKED,
    output logic DEBUG_OUTPUT_A,
    output logic DEBUG_OUTPUT_B,
    output var tdc_delay_cmd_t DELAY_CMD,
    output logic DELAY_STEP
);
    function automatic logic tdc_pick(input logic [TDC_NUM_CH-1:0] v, input logic [4:0] sel);
        tdc_pick = (sel < 5'(TDC_NUM_CH)) ? v[sel[3:0]] : 1'b0;
    endfunction

    function automatic logic tdc_edge(input logic cur, input logic prev, input logic neg);
        tdc_edge = neg ? (prev & ~cur) : (cur & ~prev);
    endfunction

    function automatic logic signed [15:0] tdc_step(input logic signed [15:0] rem, input logic one,
                                                    input logic big);
        logic signed [15:0] unit;
        unit = big ? TDC_STEP_BIG : TDC_STEP_SMALL;
        if (one) begin
            tdc_step = rem;
        end else if (rem > unit) begin
            tdc_step = unit;
        end else if (rem < -unit) begin
            tdc_step = -unit;
        end else begin
            tdc_step = rem;
        end
    endfunction

    // Software registers
    logic [7:0] tgt_r, src_r, edge_r, arm_r, fine_r, cdlo_r, cdhi_r, step_r, errclr_r;
    logic [20:0] com_r;
    logic [11:0] output_divider_value_r;
    // Engine state
    tdc_mstate_t state_r, st_nxt;
    logic [31:0] acc_r, acc_nxt;
    logic [21:0] samp_r, samp_nxt;
    logic [9:0] cnt_r, cnt_nxt;
    logic [1:0] post_r, post_nxt;
    logic [2:0] pass_r, pass_nxt;
    logic loop_r, loop_nxt;
    logic [1:0] err_r, err_set;
    logic [23:0] result_r;
    logic res_load, adj_go;
    logic [TDC_NUM_CH-1:0] sync1_r, sync2_r;
    logic pll1_r, pll2_r, src_prev_r, tgt_prev_r;
    logic [5:0] fine_ch_r [0:TDC_NUM_CH-1];
    logic [15:0] coarse_ch_r [0:TDC_NUM_CH-1];
    logic drun_r;
    logic signed [15:0] rem_r;
    logic [3:0] dchan_r;
    logic [7:0] rd_mux;
    logic [15:0] ofs_word;

    // Address decode
    wire hit_tgt = (ADDR == TDC_A_TARGET);
    wire hit_src = (ADDR == TDC_A_SOURCE);
    wire hit_edge = (ADDR == TDC_A_EDGE);
    wire hit_arm = (ADDR == TDC_A_ARM);
    wire hit_fine = (ADDR == TDC_A_FINE);
    wire hit_ofs = (ADDR >= TDC_A_OFS0) && (ADDR <= TDC_A_OFS19);
    wire hit_frb = (ADDR >= TDC_A_FRB0) && (ADDR <= TDC_A_FRB9);
    wire hit_tap = (ADDR >= TDC_A_TAP0) && (ADDR <= TDC_A_TAP4);
    wire [7:0] ofs_off = ADDR - TDC_A_OFS0;
    wire [7:0] frb_off = ADDR - TDC_A_FRB0;
    wire [7:0] tap_off = ADDR - TDC_A_TAP0;
    wire [3:0] tap_lo = {tap_off[2:0], 1'b0};
    wire [3:0] tap_hi = {tap_off[2:0], 1'b1};

    // Channel selection and edges
    wire [4:0] src_sel = src_r[4:0]; // [RQ4]
    wire [4:0] tgt_sel = tgt_r[4:0]; // [RQ4]
    wire tgt_valid = (tgt_sel < 5'(TDC_NUM_CH));
    wire src_cur = tdc_pick(sync2_r, src_sel);
    wire tgt_cur = tdc_pick(sync2_r, tgt_sel);
    wire src_edge = tdc_edge(src_cur, src_prev_r, edge_r[TDC_B_SRCNEG]); // [RQ5]
    wire tgt_edge = tdc_edge(tgt_cur, tgt_prev_r, edge_r[TDC_B_TGTNEG]); // [RQ5]

    // Start conditions
    wire idle = (state_r == TDC_M_IDLE);
    wire meas_go = WR && hit_arm && WDATA[TDC_B_ARM] && !arm_r[TDC_B_ARM]
                   && src_r[TDC_B_MANUAL] && idle && !drun_r; // [RQ3] [RQ7] [RQ8]
    wire loop_go = WR && hit_tgt && !src_r[TDC_B_MANUAL] && pll2_r && idle && !drun_r
                   && (WDATA[4:0] < 5'(TDC_NUM_CH)); // [RQ1] [RQ22]
    wire adj_wr = WR && hit_fine && WDATA[TDC_B_START] && !fine_r[TDC_B_START] && pll2_r
                  && idle && !drun_r && tgt_valid; // [RQ1] [RQ17]
    wire [21:0] samp_last = (22'h000001 << (TDC_AVG_BASE_LOG2 + int'(arm_r[3:0]))) - 22'h000001; // [RQ2]
    wire meas_running = (state_r == TDC_M_WAIT_SRC) || (state_r == TDC_M_WAIT_TGT); // [RQ9]
    wire post_running = (state_r == TDC_M_POST); // [RQ11]
    wire loop_running = loop_r && !idle;

    // Closed-loop correction: desired minus scaled measurement
    wire signed [47:0] meas_scaled = $signed({24'h000000, result_r} * {36'h000000000, output_divider_value_r})
                                     <<< TDC_OFS_SHIFT; // [RQ21]
    wire signed [47:0] desired = 48'($signed(ofs_word)) + 48'($signed(com_r)); // [RQ19] [RQ20]
    wire signed [47:0] corr_total = desired - meas_scaled;
    wire signed [47:0] corr_shift = corr_total >>> TDC_COARSE_SHIFT;
    wire signed [15:0] corr_coarse = corr_shift[15:0];

    wire signed [15:0] step_amt = tdc_step(rem_r, step_r[TDC_B_ONESHOT], step_r[TDC_B_BIGSTEP]); // [RQ16]
    wire signed [15:0] rem_next = rem_r - step_amt;
    wire do_step = drun_r && tgt_edge;
    wire [15:0] coarse_next = coarse_ch_r[dchan_r] + step_amt;

    tdc_offset_mem u_ofs (
        .clk(MCLK),
        .rst(RST),
        .we(WR && hit_ofs),
        .waddr(ofs_off[4:1]),
        .whigh(ofs_off[0]),
        .wdata(WDATA),
        .raddr(tgt_sel[3:0]),
        .rdata(ofs_word)
    );

    // Pin synchronisers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sync1_r <= '0;
            sync2_r <= '0;
            pll1_r <= 1'b0;
            pll2_r <= 1'b0;
            src_prev_r <= 1'b0;
            tgt_prev_r <= 1'b0;
        end else begin
            sync1_r <= SYNC_CHANNEL_IN;
            sync2_r <= sync1_r;
            pll1_r <= PLL_LOCKED;
            pll2_r <= pll1_r;
            src_prev_r <= src_cur;
            tgt_prev_r <= tgt_cur;
        end
    end

    // Software register writes
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            tgt_r <= 8'h00;
            src_r <= 8'h00;
            edge_r <= 8'h00;
            arm_r <= TDC_ARM_RST;
            fine_r <= 8'h00;
            cdlo_r <= 8'h00;
            cdhi_r <= 8'h00;
            step_r <= 8'h00;
            errclr_r <= 8'h00;
            com_r <= 21'h000000;
            output_divider_value_r <= TDC_OUTPUT_DIVIDER_VALUE_RST;
        end else if (WR) begin
            if (hit_tgt) begin
                tgt_r <= WDATA;
            end else if (hit_src) begin
                src_r <= WDATA;
            end else if (hit_edge) begin
                edge_r <= WDATA;
            end else if (hit_arm) begin
                arm_r <= WDATA;
            end else if (hit_fine) begin
                fine_r <= WDATA;
            end else if (ADDR == TDC_A_CDLO) begin
                cdlo_r <= WDATA;
            end else if (ADDR == TDC_A_CDHI) begin
                cdhi_r <= WDATA;
            end else if (ADDR == TDC_A_STEP) begin
                step_r <= WDATA;
            end else if (ADDR == TDC_A_ERRCLR) begin
                errclr_r <= WDATA;
            end else if (ADDR == TDC_A_COM0) begin
                com_r[7:0] <= WDATA;
            end else if (ADDR == TDC_A_COM1) begin
                com_r[15:8] <= WDATA;
            end else if (ADDR == TDC_A_COM2) begin
                com_r[20:16] <= WDATA[4:0];
            end else if (ADDR == TDC_A_ODIV0) begin
                output_divider_value_r[7:0] <= WDATA;
            end else if (ADDR == TDC_A_ODIV1) begin
                output_divider_value_r[11:8] <= WDATA[3:0];
            end
        end
    end

    // Measurement and closed-loop sequencer
    always_comb begin
        st_nxt = state_r;
        acc_nxt = acc_r;
        samp_nxt = samp_r;
        cnt_nxt = cnt_r;
        post_nxt = post_r;
        pass_nxt = pass_r;
        loop_nxt = loop_r;
        err_set = 2'b00;
        res_load = 1'b0;
        adj_go = 1'b0;
        case (state_r)
            TDC_M_IDLE: begin
                if (meas_go || loop_go) begin
                    st_nxt = TDC_M_WAIT_SRC;
                    acc_nxt = 32'h00000000;
                    samp_nxt = 22'h000000;
                    cnt_nxt = 10'h000;
                    pass_nxt = 3'h0;
                    loop_nxt = loop_go;
                end
            end
            TDC_M_WAIT_SRC: begin
                if (src_edge) begin
                    st_nxt = TDC_M_WAIT_TGT;
                    cnt_nxt = 10'h001; // Edge cycle counts as one
                end else if (cnt_r == TDC_EDGE_TIMEOUT_CYC) begin
                    err_set[0] = 1'b1; // [RQ10]
                    st_nxt = TDC_M_POST;
                end else begin
                    cnt_nxt = cnt_r + 10'h001;
                end
            end
            TDC_M_WAIT_TGT: begin
                if (tgt_edge) begin
                    acc_nxt = acc_r + 32'(cnt_r);
                    samp_nxt = samp_r + 22'h000001;
                    cnt_nxt = 10'h000;
                    st_nxt = (samp_r == samp_last) ? TDC_M_POST : TDC_M_WAIT_SRC; // [RQ2] [RQ9]
                end else if (cnt_r == TDC_EDGE_TIMEOUT_CYC) begin
                    err_set[1] = 1'b1; // [RQ10]
                    st_nxt = TDC_M_POST;
                end else begin
                    cnt_nxt = cnt_r + 10'h001;
                end
            end
            TDC_M_POST: begin
                if (post_r == TDC_POST_CYCLES - 2'h1) begin
                    res_load = (err_r == 2'b00); // [RQ23]
                    post_nxt = 2'h0;
                    st_nxt = (loop_r && err_r == 2'b00) ? TDC_M_ADJUST : TDC_M_IDLE; // [RQ11]
                end else begin
                    post_nxt = post_r + 2'h1;
                end
            end
            TDC_M_ADJUST: begin
                adj_go = 1'b1; // [RQ22]
                st_nxt = TDC_M_SETTLE;
            end
            TDC_M_SETTLE: begin
                if (!drun_r) begin
                    pass_nxt = pass_r + 3'h1;
                    acc_nxt = 32'h00000000;
                    samp_nxt = 22'h000000;
                    cnt_nxt = 10'h000;
                    st_nxt = (pass_r == TDC_LOOP_PASSES - 3'h1) ? TDC_M_IDLE : TDC_M_WAIT_SRC; // [RQ22]
                end
            end
            default: st_nxt = TDC_M_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_r <= TDC_M_IDLE;
            acc_r <= 32'h00000000;
            samp_r <= 22'h000000;
            cnt_r <= 10'h000;
            post_r <= 2'h0;
            pass_r <= 3'h0;
            loop_r <= 1'b0;
            err_r <= 2'b00;
            result_r <= 24'h000000;
        end else begin
            state_r <= st_nxt;
            acc_r <= acc_nxt;
            samp_r <= samp_nxt;
            cnt_r <= cnt_nxt;
            post_r <= post_nxt;
            pass_r <= pass_nxt;
            loop_r <= loop_nxt;
            err_r <= (errclr_r[TDC_B_ERRCLR] ? 2'b00 : err_r) | err_set; // [RQ6] [RQ10]
            if (res_load) begin
                result_r <= 24'(acc_r >> (TDC_AVG_BASE_LOG2 + int'(arm_r[3:0]))); // [RQ12] [RQ23]
            end
        end
    end

    // Delay adjust engine; output flops load as the busy flag rises, and coarse loads again on each step
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            drun_r <= 1'b0;
            rem_r <= 16'sh0000;
            dchan_r <= 4'h0;
            DELAY_CMD <= '0;
            DELAY_STEP <= 1'b0;
            for (int i = 0; i < TDC_NUM_CH; i++) begin
                fine_ch_r[i] <= 6'h00;
                coarse_ch_r[i] <= 16'h0000;
            end
        end else begin
            DELAY_STEP <= 1'b0;
            if (adj_wr || adj_go) begin
                drun_r <= 1'b1; // [RQ17]
                dchan_r <= tgt_sel[3:0];
                rem_r <= adj_wr ? $signed({cdhi_r, cdlo_r}) : corr_coarse; // [RQ14] [RQ22]
                if (adj_wr) begin
                    fine_ch_r[tgt_sel[3:0]] <= WDATA[5:0]; // [RQ13] [RQ18]
                end
                DELAY_CMD <= '{chan: tgt_sel[3:0],
                               fine: adj_wr ? WDATA[5:0] : fine_ch_r[tgt_sel[3:0]],
                               coarse: coarse_ch_r[tgt_sel[3:0]]}; // [RQ13] [RQ15]
            end else if (do_step) begin
                coarse_ch_r[dchan_r] <= coarse_next; // [RQ14]
                rem_r <= rem_next;
                DELAY_CMD.coarse <= coarse_next; // [RQ15] [RQ16]
                DELAY_STEP <= 1'b1;
                if (rem_next == 16'sh0000) begin
                    drun_r <= 1'b0; // [RQ17]
                end
            end
        end
    end

    // Register read mux
    always_comb begin
        if (hit_tgt) begin
            rd_mux = tgt_r;
        end else if (hit_src) begin
            rd_mux = src_r;
        end else if (hit_edge) begin
            rd_mux = edge_r;
        end else if (hit_arm) begin
            rd_mux = arm_r;
        end else if (hit_fine) begin
            rd_mux = fine_r;
        end else if (ADDR == TDC_A_CDLO) begin
            rd_mux = cdlo_r;
        end else if (ADDR == TDC_A_CDHI) begin
            rd_mux = cdhi_r;
        end else if (ADDR == TDC_A_STEP) begin
            rd_mux = step_r;
        end else if (ADDR == TDC_A_ERRCLR) begin
            rd_mux = errclr_r;
        end else if (ADDR == TDC_A_RES0) begin
            rd_mux = result_r[7:0]; // [RQ12]
        end else if (ADDR == TDC_A_RES1) begin
            rd_mux = result_r[15:8]; // [RQ12]
        end else if (ADDR == TDC_A_RES2) begin
            rd_mux = result_r[23:16]; // [RQ12]
        end else if (hit_frb) begin
            rd_mux = {2'b00, fine_ch_r[frb_off[3:0]]}; // [RQ18]
        end else if (hit_tap) begin
            rd_mux = {1'b0, coarse_ch_r[tap_hi][2:0], 1'b0, coarse_ch_r[tap_lo][2:0]}; // [RQ18]
        end else if (ADDR == TDC_A_BUSY) begin
            rd_mux = {3'b000, meas_running, drun_r, post_running, 1'b0, loop_running}; // [RQ9] [RQ11] [RQ17]
        end else if (ADDR == TDC_A_ERR) begin
            rd_mux = {5'b00000, err_r, 1'b0}; // [RQ10]
        end else if (ADDR == TDC_A_COM0) begin
            rd_mux = com_r[7:0];
        end else if (ADDR == TDC_A_COM1) begin
            rd_mux = com_r[15:8];
        end else if (ADDR == TDC_A_COM2) begin
            rd_mux = {3'b000, com_r[20:16]};
        end else if (ADDR == TDC_A_ODIV0) begin
            rd_mux = output_divider_value_r[7:0];
        end else if (ADDR == TDC_A_ODIV1) begin
            rd_mux = {4'h0, output_divider_value_r[11:8]};
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
            DEBUG_OUTPUT_A <= 1'b0;
            DEBUG_OUTPUT_B <= 1'b0;
        end else begin
            RDATA <= RD ? rd_mux : 8'h00;
            DEBUG_OUTPUT_A <= meas_running; // [RQ9]
            DEBUG_OUTPUT_B <= meas_running; // [RQ9]
        end
    end
endmodule // tdc_measure_adjust
`default_nettype wire

// [common/tdc_pkg.sv]
package tdc_pkg;
    // Register offsets
    localparam logic [7:0] TDC_A_TARGET = 8'h10;
    localparam logic [7:0] TDC_A_SOURCE = 8'h11;
    localparam logic [7:0] TDC_A_EDGE = 8'h15;
    localparam logic [7:0] TDC_A_ARM = 8'h16;
    localparam logic [7:0] TDC_A_FINE = 8'h17;
    localparam logic [7:0] TDC_A_CDLO = 8'h18;
    localparam logic [7:0] TDC_A_CDHI = 8'h19;
    localparam logic [7:0] TDC_A_STEP = 8'h34;
    localparam logic [7:0] TDC_A_ERRCLR = 8'h61;
    localparam logic [7:0] TDC_A_RES0 = 8'h73;
    localparam logic [7:0] TDC_A_RES1 = 8'h74;
    localparam logic [7:0] TDC_A_RES2 = 8'h75;
    localparam logic [7:0] TDC_A_FRB0 = 8'h84;
    localparam logic [7:0] TDC_A_FRB9 = 8'h8d;
    localparam logic [7:0] TDC_A_BUSY = 8'h8f;
    localparam logic [7:0] TDC_A_ERR = 8'h90;
    localparam logic [7:0] TDC_A_TAP0 = 8'h95;
    localparam logic [7:0] TDC_A_TAP4 = 8'h99;
    localparam logic [7:0] TDC_A_OFS0 = 8'ha0;
    localparam logic [7:0] TDC_A_OFS19 = 8'hb3;
    localparam logic [7:0] TDC_A_COM0 = 8'hb4;
    localparam logic [7:0] TDC_A_COM1 = 8'hb5;
    localparam logic [7:0] TDC_A_COM2 = 8'hb6;
    localparam logic [7:0] TDC_A_ODIV0 = 8'hb8;
    localparam logic [7:0] TDC_A_ODIV1 = 8'hb9;
    // Bit positions
    localparam int TDC_B_MANUAL = 7;
    localparam int TDC_B_ARM = 7;
    localparam int TDC_B_START = 7;
    localparam int TDC_B_ONESHOT = 7;
    localparam int TDC_B_BIGSTEP = 6;
    localparam int TDC_B_ERRCLR = 7;
    localparam int TDC_B_SRCNEG = 7;
    localparam int TDC_B_TGTNEG = 6;
    // Reset values
    localparam logic [7:0] TDC_ARM_RST = 8'h06;
    localparam logic [11:0] TDC_OUTPUT_DIVIDER_VALUE_RST = 12'h001;
    // Sizes and weights
    localparam int TDC_NUM_CH = 10;
    localparam int TDC_AVG_BASE_LOG2 = 6;
    localparam int TDC_OFS_SHIFT = 9;
    localparam int TDC_COARSE_SHIFT = 6;
    localparam logic signed [15:0] TDC_STEP_SMALL = 16'sh0001;
    localparam logic signed [15:0] TDC_STEP_BIG = 16'sh0008;
    localparam logic [2:0] TDC_LOOP_PASSES = 3'h2;
    localparam logic [1:0] TDC_POST_CYCLES = 2'h2;
    // Timing
    localparam int TDC_CLK_PERIOD_NS = 20;
    localparam int TDC_EDGE_TIMEOUT_NS = 10000;
    localparam logic [9:0] TDC_EDGE_TIMEOUT_CYC = 10'(TDC_EDGE_TIMEOUT_NS / TDC_CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        TDC_M_IDLE = 3'b000,
        TDC_M_WAIT_SRC = 3'b001,
        TDC_M_WAIT_TGT = 3'b010,
        TDC_M_POST = 3'b011,
        TDC_M_ADJUST = 3'b100,
        TDC_M_SETTLE = 3'b101
    } tdc_mstate_t;

    typedef struct packed {
        logic [3:0] chan;
        logic [5:0] fine;
        logic [15:0] coarse;
    } tdc_delay_cmd_t;
endpackage

// [rtl/tdc_offset_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module tdc_offset_mem
import tdc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic whigh,
    input wire logic [7:0] wdata,
    input wire logic [3:0] raddr,
    output logic [15:0] rdata
);
    logic [7:0] mem_lo [0:15];
    logic [7:0] mem_hi [0:15];

    always_ff @(posedge clk) begin
        if (we && !whigh) begin
            mem_lo[waddr] <= wdata;
        end
        if (we && whigh) begin
            mem_hi[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= {mem_hi[raddr], mem_lo[raddr]};
        end
    end
endmodule // tdc_offset_mem
`default_nettype wire

// [verif/tdc_measure_adjust_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module tdc_measure_adjust_checker
import tdc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic [TDC_NUM_CH-1:0] SYNC_CHANNEL_IN,
    input wire logic PLL_LOCKED,
    input wire logic DEBUG_OUTPUT_A,
    input wire logic DEBUG_OUTPUT_B,
    input wire tdc_delay_cmd_t DELAY_CMD,
    input wire logic DELAY_STEP
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    logic manual_r;
    // Closed-loop passes raise busy without an arm write
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            manual_r <= 1'b0;
        end else if (WR && ADDR == TDC_A_SOURCE) begin
            manual_r <= WDATA[TDC_B_MANUAL];
        end
    end
    property p_idle;
        !$past(RD) |-> RDATA == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_pins;
        DEBUG_OUTPUT_A == DEBUG_OUTPUT_B;
    endproperty
    a_pins: assert property (p_pins) else $error("debug pins differ");
    property p_flag;
        $past(RD) && $past(ADDR) == TDC_A_BUSY |-> RDATA[4] == DEBUG_OUTPUT_A;
    endproperty
    a_flag: assert property (p_flag) else $error("busy bit and pin differ");
    property p_start;
        $rose(DEBUG_OUTPUT_A) && manual_r |-> $past(WR, 2) && $past(ADDR, 2) == TDC_A_ARM && $past(WDATA, 2) >= 8'h80;
    endproperty
    a_start: assert property (p_start) else $error("busy without arm");
    property p_long;
        $fell(DEBUG_OUTPUT_A) |-> $past(DEBUG_OUTPUT_A, 64);
    endproperty
    a_long: assert property (p_long) else $error("busy too short");
    property p_pulse;
        DELAY_STEP |=> !DELAY_STEP;
    endproperty
    a_pulse: assert property (p_pulse) else $error("step pulse too long");
    property p_coarse;
        $changed(DELAY_CMD.coarse) |-> DELAY_STEP || $changed(DELAY_CMD.chan);
    endproperty
    a_coarse: assert property (p_coarse) else $error("coarse moved without step");
    property p_lock;
        DELAY_STEP |-> PLL_LOCKED;
    endproperty
    a_lock: assert property (p_lock) else $error("step while unlocked");
endmodule // tdc_measure_adjust_checker
bind tdc_measure_adjust tdc_measure_adjust_checker tdc_measure_adjust_checker_inst (.*);
`default_nettype wire

// [verif/tb_tdc_measure_adjust.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_tdc_measure_adjust import tdc_pkg::*; ;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic locked = 1'b0;
    logic dbg_a, dbg_b, step;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, rv;
    logic [TDC_NUM_CH-1:0] sync = '0;
    tdc_delay_cmd_t cmd;
    int err_total = 0;
    int n_compared = 0;
    int steps = 0;
    int n;
    logic [7:0] tbl [6][3] = '{'{TDC_A_TARGET, 8'h03, 8'h03}, '{TDC_A_SOURCE, 8'h81, 8'h81},
        '{TDC_A_EDGE, 8'hc0, 8'hc0}, '{TDC_A_CDLO, 8'h10, 8'h10}, '{TDC_A_CDHI, 8'h00, 8'h00},
        '{TDC_A_STEP, 8'h40, 8'h40}};
    tdc_measure_adjust tdc_measure_adjust_inst (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SYNC_CHANNEL_IN(sync), .PLL_LOCKED(locked), .DEBUG_OUTPUT_A(dbg_a),
        .DEBUG_OUTPUT_B(dbg_b), .DELAY_CMD(cmd), .DELAY_STEP(step));
    initial begin
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) steps <= steps + int'(step === 1'b1);
    task automatic test_done();
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [25:0] seen, input logic [25:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        rv = rdata;
    endtask
    task automatic wait_low(input logic [7:0] m, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            r(TDC_A_BUSY);
            if ((rv & m) === 8'h00) break;
        end
        if (i == lim) begin
            err_total++;
            test_done();
        end
    endtask
    // Source edge, target edge five cycles later
    task automatic edges(input int s, input int t, input int cnt);
        repeat (cnt) begin
            @(posedge mclk);
            sync[s] <= 1'b1;
            repeat (5) @(posedge mclk);
            sync[t] <= 1'b1;
            repeat (4) @(posedge mclk);
            sync <= '0;
            repeat (6) @(posedge mclk);
        end
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        r(TDC_A_ARM);
        check("arm reset", rv, TDC_ARM_RST);
        r(8'h00);
        check("unmapped", rv, 8'h00);
        for (int i = 0; i < 6; i++) begin
            w(tbl[i][0], tbl[i][1]);
            r(tbl[i][0]);
            check("reg", rv, tbl[i][2]);
        end
        w(TDC_A_TARGET, 8'h02);
        w(TDC_A_EDGE, 8'h00);
        w(TDC_A_ERRCLR, 8'h80);
        w(TDC_A_ERRCLR, 8'h00);
        w(TDC_A_ARM, 8'h80);
        r(TDC_A_BUSY);
        check("meas busy", {rv[4], dbg_a}, 2'b11);
        edges(1, 2, 64);
        wait_low(8'h14, 50);
        for (int i = 0; i < 3; i++) begin
            r(TDC_A_RES0 + 8'(i));
            check("result", rv, i == 0 ? 8'h05 : 8'h00);
        end
        r(TDC_A_ERR);
        check("no error", rv, 8'h00);
        w(TDC_A_ARM, 8'h00);
        w(TDC_A_ARM, 8'h80);
        wait_low(8'h14, 400);
        r(TDC_A_ERR);
        check("timeout error", rv, 8'h02);
        r(TDC_A_RES0);
        check("result kept", rv, 8'h05);
        w(TDC_A_ERRCLR, 8'h80);
        w(TDC_A_ERRCLR, 8'h00);
        r(TDC_A_ERR);
        check("error cleared", rv, 8'h00);
        w(TDC_A_ARM, 8'h00);
        @(posedge mclk);
        locked <= 1'b1;
        w(TDC_A_TARGET, 8'h03);
        n = steps;
        w(TDC_A_FINE, 8'haa);
        r(TDC_A_BUSY);
        check("adj busy", rv[3], 1'b1);
        check("cmd", {cmd.chan, cmd.fine, cmd.coarse}, {4'h3, 6'h2a, 16'h0000});
        edges(3, 3, 3);
        wait_low(8'h08, 20);
        check("big steps", steps - n, 2);
        check("coarse", cmd.coarse, 16'h0010);
        r(TDC_A_FRB0 + 8'h03);
        check("fine readback", rv, 8'h2a);
        w(TDC_A_FINE, 8'h2a);
        w(TDC_A_CDLO, 8'h03);
        w(TDC_A_STEP, 8'h80);
        n = steps;
        w(TDC_A_FINE, 8'haa);
        edges(3, 3, 2);
        wait_low(8'h08, 20);
        check("single_cycle_apply", steps - n, 1);
        check("coarse sum", cmd.coarse, 16'h0013);
        r(TDC_A_TAP0 + 8'h01);
        check("tap", rv, 8'h30);
        // Closed loop on channel 3: offset 0x0a40 plus common 0x100 against result 5
        w(TDC_A_SOURCE, 8'h01);
        w(TDC_A_OFS0 + 8'h06, 8'h40);
        w(TDC_A_OFS0 + 8'h07, 8'h0a);
        w(TDC_A_COM1, 8'h01);
        w(TDC_A_TARGET, 8'h03);
        r(TDC_A_BUSY);
        check("loop busy", rv[0], 1'b1);
        edges(1, 3, 132);
        wait_low(8'h1d, 20);
        check("loop coarse", cmd.coarse, 16'h001d);
        r(TDC_A_RES0);
        check("loop result", rv, 8'h05);
        test_done();
    end
endmodule // tb_tdc_measure_adjust
`default_nettype wire
